// *** hdl/pmc_ctrl.sv ***
// power mode controller: sequences active, idle, standby, shutdown and held reset
// assumes one 10 MHz clock, synchronous active-low reset, wake sources from pins,
// the real-time clock and the sensor controller, and a mode request from software
`timescale 1ns/1ps
module pmc_ctrl #(
   parameter int N = pmc_pkg::PIN_COUNT
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic mode_req_valid_in,
   input wire logic [1:0] mode_req_in,
   input wire logic irq_in,
   input wire logic rtc_event_in,
   input wire logic sc_event_in,
   input wire logic reset_pin_n_in,
   input wire logic [N-1:0] pin_in,
   input wire logic [N-1:0] pin_wake_en_in,
   input wire logic [N-1:0] shdn_wake_en_in,
   input wire logic [N-1:0] gpio_core_in,
   input wire logic hf_src_sel_in,
   input wire logic [1:0] lf_src_sel_in,
   input wire logic lf_out_req_in,
   input wire logic radio_req_in,
   input wire logic sc_periph_req_in,
   output logic [2:0] mode_out,
   output logic mode_busy_out,
   output logic cpu_clk_en_out,
   output logic mem_clk_en_out,
   output logic periph_clk_en_out,
   output logic aon_pwr_out,
   output logic sc_pwr_out,
   output logic [1:0] reg_ret_out,
   output logic sram_ret_out,
   output logic periph_ret_out,
   output logic cpu_resume_out,
   output logic cpu_reset_out,
   output logic [1:0] reset_cause_out,
   output logic main_clk_en_out,
   output logic main_clk_src_out,
   output logic radio_en_out,
   output logic medium_clk_en_out,
   output logic low_clk_en_out,
   output logic [1:0] low_clk_src_out,
   output logic lf_clk_drive_out,
   output logic [N-1:0] pin_event_out,
   output logic wdt_run_out,
   output logic wdt_pause_out,
   output logic [1:0] bod_mode_out,
   output logic bod_sample_out,
   output logic por_en_out,
   output logic sc_periph_owner_out,
   output logic [N-1:0] gpio_pad_out,
   output logic gpio_latched_out
);
   pmc_pkg::pmc_state_type state_r;
   pmc_pkg::pmc_state_type state_nxt;
   pmc_pkg::pmc_req_type tgt_r;
   pmc_pkg::pmc_cause_type cause_r;
   logic [pmc_pkg::PREP_CNT_W-1:0] prep_cnt_r;
   logic [pmc_pkg::BOD_CNT_W-1:0] bod_cnt_r;
   logic pend_r;
   logic latch_r;
   logic rst_pin_level;
   logic rst_pin_change;
   logic [N-1:0] pin_level;
   logic [N-1:0] pin_change;
   logic edge_wake;
   logic shdn_wake;
   logic standby_wake;
   logic idle_wake;
   logic prep_done;
   logic live_nxt;
   pmc_pkg::pmc_lf_type lf_sel;

   pmc_pad_if #(.N(N)) pad_bus ();

   // reset pin idles high
   pmc_sync #(.W(1), .RST_VAL(1'h1)) u_rst_sync (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .async_in(reset_pin_n_in),
      .level_out(rst_pin_level),
      .change_out(rst_pin_change)
   );

   pmc_sync #(.W(N), .RST_VAL('0)) u_pin_sync (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .async_in(pin_in),
      .level_out(pin_level),
      .change_out(pin_change)
   );

   pmc_pin_latch #(.N(N)) u_latch (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .pad_if(pad_bus.latch)
   );

   // wake qualification per mode
   assign edge_wake = |(pin_change & pin_wake_en_in);
   assign shdn_wake = |(pin_change & shdn_wake_en_in);
   assign standby_wake = edge_wake | rtc_event_in | sc_event_in;
   assign idle_wake = standby_wake | irq_in;
   assign prep_done = (prep_cnt_r == '0);

   // next mode
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         pmc_pkg::ST_HELD: begin
            if (rst_pin_level) begin
               state_nxt = pmc_pkg::ST_ACTIVE;
            end
         end
         pmc_pkg::ST_ACTIVE: begin
            if (mode_req_valid_in && mode_req_in != pmc_pkg::REQ_NONE) begin
               state_nxt = pmc_pkg::ST_PREP;
            end
         end
         pmc_pkg::ST_PREP: begin
            if (prep_done) begin
               if (pend_r && tgt_r != pmc_pkg::REQ_SHUTDOWN) begin
                  state_nxt = pmc_pkg::ST_ACTIVE;
               end else if (tgt_r == pmc_pkg::REQ_IDLE) begin
                  state_nxt = pmc_pkg::ST_IDLE;
               end else if (tgt_r == pmc_pkg::REQ_STANDBY) begin
                  state_nxt = pmc_pkg::ST_STANDBY;
               end else begin
                  state_nxt = pmc_pkg::ST_SHUTDOWN;
               end
            end
         end
         pmc_pkg::ST_IDLE: begin
            if (idle_wake) begin
               state_nxt = pmc_pkg::ST_ACTIVE;
            end
         end
         pmc_pkg::ST_STANDBY: begin
            if (standby_wake) begin
               state_nxt = pmc_pkg::ST_ACTIVE;
            end
         end
         pmc_pkg::ST_SHUTDOWN: begin
            if (shdn_wake) begin
               state_nxt = pmc_pkg::ST_HELD;
            end
         end
         default: begin
            state_nxt = pmc_pkg::ST_HELD;
         end
      endcase
      if (!rst_pin_level) begin
         state_nxt = pmc_pkg::ST_HELD;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         state_r <= pmc_pkg::ST_HELD;
      end else begin
         state_r <= state_nxt;
      end
   end

   // target mode and setup countdown
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         tgt_r <= pmc_pkg::REQ_NONE;
         prep_cnt_r <= '0;
      end else if (state_r == pmc_pkg::ST_ACTIVE && state_nxt == pmc_pkg::ST_PREP) begin
         tgt_r <= pmc_pkg::pmc_req_type'(mode_req_in);
         prep_cnt_r <= pmc_pkg::PREP_CNT_W'(pmc_pkg::PREP_CYC - 1);
      end else if (state_r == pmc_pkg::ST_PREP && !prep_done) begin
         prep_cnt_r <= prep_cnt_r - 1'b1;
      end
   end

   // a wake arriving before the last cycle of idle or standby setup is kept and turns the entry back
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         pend_r <= 1'b0;
      end else if (state_r != pmc_pkg::ST_PREP) begin
         pend_r <= 1'b0;
      end else if (tgt_r == pmc_pkg::REQ_IDLE && idle_wake) begin
         pend_r <= 1'b1;
      end else if (tgt_r == pmc_pkg::REQ_STANDBY && standby_wake) begin
         pend_r <= 1'b1;
      end
   end

   // reset cause, power-on after system reset
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         cause_r <= pmc_pkg::CAUSE_POR;
      end else if (!rst_pin_level) begin
         cause_r <= pmc_pkg::CAUSE_PIN;
      end else if (state_r == pmc_pkg::ST_SHUTDOWN && state_nxt == pmc_pkg::ST_HELD) begin
         cause_r <= pmc_pkg::CAUSE_SHDN_WAKE;
      end
   end

   assign reset_cause_out = cause_r;

   // power domains, clock gating and retention per mode
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         cpu_clk_en_out <= 1'b0;
         mem_clk_en_out <= 1'b0;
         periph_clk_en_out <= 1'b0;
         aon_pwr_out <= 1'b0;
         sc_pwr_out <= 1'b0;
         reg_ret_out <= pmc_pkg::RET_NONE;
         sram_ret_out <= 1'b0;
         periph_ret_out <= 1'b0;
      end else begin
         cpu_clk_en_out <= state_nxt == pmc_pkg::ST_ACTIVE;
         mem_clk_en_out <= state_nxt == pmc_pkg::ST_ACTIVE;
         periph_clk_en_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP;
         aon_pwr_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP
            || state_nxt == pmc_pkg::ST_STANDBY;
         sc_pwr_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP
            || state_nxt == pmc_pkg::ST_STANDBY;
         unique case (state_nxt)
            pmc_pkg::ST_ACTIVE, pmc_pkg::ST_IDLE, pmc_pkg::ST_PREP: begin
               reg_ret_out <= pmc_pkg::RET_FULL;
            end
            pmc_pkg::ST_STANDBY: begin
               reg_ret_out <= pmc_pkg::RET_PARTIAL;
            end
            default: begin
               reg_ret_out <= pmc_pkg::RET_NONE;
            end
         endcase
         sram_ret_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP
            || state_nxt == pmc_pkg::ST_STANDBY;
         periph_ret_out <= state_nxt == pmc_pkg::ST_STANDBY;
      end
   end

   assign live_nxt = state_nxt == pmc_pkg::ST_ACTIVE || state_nxt == pmc_pkg::ST_IDLE;

   // cpu resume and reset controls
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         cpu_resume_out <= 1'b0;
         cpu_reset_out <= 1'b1;
      end else begin
         cpu_resume_out <= (state_r == pmc_pkg::ST_STANDBY || state_r == pmc_pkg::ST_IDLE)
            && state_nxt == pmc_pkg::ST_ACTIVE;
         cpu_reset_out <= state_nxt == pmc_pkg::ST_HELD;
      end
   end

   // system clock selection
   assign lf_sel = (lf_src_sel_in == pmc_pkg::LF_SRC_XTAL) ? pmc_pkg::LF_SRC_XTAL
      : (lf_src_sel_in == pmc_pkg::LF_SRC_EXT) ? pmc_pkg::LF_SRC_EXT : pmc_pkg::LF_SRC_RC;

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         main_clk_en_out <= 1'b0;
         main_clk_src_out <= pmc_pkg::HF_SRC_RC;
         radio_en_out <= 1'b0;
         medium_clk_en_out <= 1'b0;
         low_clk_en_out <= 1'b0;
         low_clk_src_out <= pmc_pkg::LF_SRC_RC;
         lf_clk_drive_out <= 1'b0;
      end else begin
         main_clk_en_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP;
         main_clk_src_out <= hf_src_sel_in;
         radio_en_out <= radio_req_in && hf_src_sel_in == pmc_pkg::HF_SRC_XTAL
            && live_nxt;
         medium_clk_en_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP
            || state_nxt == pmc_pkg::ST_STANDBY;
         low_clk_en_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP
            || state_nxt == pmc_pkg::ST_STANDBY;
         low_clk_src_out <= lf_sel;
         lf_clk_drive_out <= lf_out_req_in && lf_sel != pmc_pkg::LF_SRC_EXT
            && (live_nxt || state_nxt == pmc_pkg::ST_PREP
            || state_nxt == pmc_pkg::ST_STANDBY);
      end
   end

   // pin edge events, suppressed while reset is held
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         pin_event_out <= '0;
      end else if (state_r == pmc_pkg::ST_HELD) begin
         pin_event_out <= '0;
      end else begin
         pin_event_out <= pin_change & pin_wake_en_in;
      end
   end

   // supervisors
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         wdt_run_out <= 1'b0;
         wdt_pause_out <= 1'b0;
         bod_mode_out <= pmc_pkg::BOD_OFF;
         por_en_out <= 1'b0;
      end else begin
         wdt_run_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP;
         wdt_pause_out <= state_nxt == pmc_pkg::ST_STANDBY;
         if (state_nxt == pmc_pkg::ST_STANDBY) begin
            bod_mode_out <= pmc_pkg::BOD_DUTY;
         end else if (live_nxt || state_nxt == pmc_pkg::ST_PREP) begin
            bod_mode_out <= pmc_pkg::BOD_ON;
         end else begin
            bod_mode_out <= pmc_pkg::BOD_OFF;
         end
         por_en_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP
            || state_nxt == pmc_pkg::ST_STANDBY;
      end
   end

   // brownout sample strobe: steady in run modes, one cycle per period in standby
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         bod_cnt_r <= '0;
      end else if (state_r != pmc_pkg::ST_STANDBY || bod_cnt_r == '0) begin
         bod_cnt_r <= pmc_pkg::BOD_CNT_W'(pmc_pkg::BOD_PERIOD_CYC - 1);
      end else begin
         bod_cnt_r <= bod_cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         bod_sample_out <= 1'b0;
      end else if (state_r == pmc_pkg::ST_STANDBY && state_nxt == pmc_pkg::ST_STANDBY) begin
         bod_sample_out <= bod_cnt_r == '0;
      end else begin
         bod_sample_out <= live_nxt || state_nxt == pmc_pkg::ST_PREP;
      end
   end

   // sensor controller peripheral ownership; cpu owns them otherwise
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         sc_periph_owner_out <= 1'b0;
      end else begin
         sc_periph_owner_out <= sc_periph_req_in && (live_nxt
            || state_nxt == pmc_pkg::ST_PREP || state_nxt == pmc_pkg::ST_STANDBY);
      end
   end

   // pin latch in standby and shutdown
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         latch_r <= 1'b0;
      end else begin
         latch_r <= state_nxt == pmc_pkg::ST_STANDBY
            || state_nxt == pmc_pkg::ST_SHUTDOWN;
      end
   end

   assign pad_bus.latch_en = latch_r;
   assign pad_bus.core_val = gpio_core_in;
   assign gpio_pad_out = pad_bus.pad_val;
   assign gpio_latched_out = latch_r;

   assign mode_out = state_r;
   assign mode_busy_out = state_r == pmc_pkg::ST_PREP;
endmodule

// *** common/pmc_pkg.sv ***
// constants and types shared by the power mode controller files
// assumes a single 10 MHz clock and no software-visible register map
package pmc_pkg;

   // clock period of clock_in
   localparam int CLK_PERIOD_NS = 100;

   // least time spent gating clocks and arming retention before a low-power mode
   localparam int PREP_TIME_NS = 1000;
   localparam int PREP_CYC = (PREP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PREP_CNT_W = $clog2(PREP_CYC + 1);

   // brownout detector sampling period while duty-cycled
   localparam int BOD_PERIOD_NS = 10000;
   localparam int BOD_PERIOD_CYC = BOD_PERIOD_NS / CLK_PERIOD_NS;
   localparam int BOD_CNT_W = $clog2(BOD_PERIOD_CYC + 1);

   // nominal rates of the three system clocks
   localparam int MAIN_CLK_HZ = 48000000;
   localparam int MEDIUM_CLK_HZ = 2000000;
   localparam int LOW_CLK_HZ = 32768;

   // number of general-purpose pins handled
   localparam int PIN_COUNT = 8;

   typedef enum logic [2:0] {
      ST_ACTIVE = 3'h0,
      ST_PREP = 3'h1,
      ST_IDLE = 3'h3,
      ST_STANDBY = 3'h2,
      ST_SHUTDOWN = 3'h6,
      ST_HELD = 3'h4
   } pmc_state_type;

   typedef enum logic [1:0] {
      REQ_NONE = 2'h0,
      REQ_IDLE = 2'h1,
      REQ_STANDBY = 2'h2,
      REQ_SHUTDOWN = 2'h3
   } pmc_req_type;

   typedef enum logic [1:0] {
      RET_NONE = 2'h0,
      RET_PARTIAL = 2'h1,
      RET_FULL = 2'h2
   } pmc_ret_type;

   typedef enum logic [1:0] {
      CAUSE_POR = 2'h0,
      CAUSE_PIN = 2'h1,
      CAUSE_SHDN_WAKE = 2'h2
   } pmc_cause_type;

   typedef enum logic [1:0] {
      LF_SRC_RC = 2'h0,
      LF_SRC_XTAL = 2'h1,
      LF_SRC_EXT = 2'h2
   } pmc_lf_type;

   typedef enum logic {
      HF_SRC_RC = 1'h0,
      HF_SRC_XTAL = 1'h1
   } pmc_hf_type;

   typedef enum logic [1:0] {
      BOD_OFF = 2'h0,
      BOD_ON = 2'h1,
      BOD_DUTY = 2'h2
   } pmc_bod_type;

endpackage

// *** common/pmc_pad_if.sv ***
// carries pin values between the mode controller and its pin latch
// assumes both ends run on clock_in
`timescale 1ns/1ps
interface pmc_pad_if #(parameter int N = 8);
   logic latch_en;
   logic [N-1:0] core_val;
   logic [N-1:0] pad_val;

   modport ctrl (output latch_en, output core_val, input pad_val);
   modport latch (input latch_en, input core_val, output pad_val);
endinterface

// *** hdl/pmc_sync.sv ***
// three-stage synchroniser for asynchronous pin levels
// a change is accepted once the second and third stages agree
`timescale 1ns/1ps
module pmc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level_out,
   output logic [W-1:0] change_out
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] agree;

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign agree = ~(s2_r ^ s3_r);

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         level_out <= RST_VAL;
         change_out <= '0;
      end else begin
         level_out <= (agree & s3_r) | (~agree & level_out);
         change_out <= agree & (s3_r ^ level_out);
      end
   end
endmodule

// *** hdl/pmc_pin_latch.sv ***
// pin output latch: passes core values, freezes them while latch_en is high
// assumes latch_en is a registered level from the controller
`timescale 1ns/1ps
module pmc_pin_latch #(
   parameter int N = 8
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   pmc_pad_if.latch pad_if
);
   logic [N-1:0] pad_r;

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         pad_r <= '0;
      end else if (!pad_if.latch_en) begin
         pad_r <= pad_if.core_val;
      end
   end

   assign pad_if.pad_val = pad_r;
endmodule

// *** bench/pmc_ctrl_asserts.sv ***
// port-level assertions for the power mode controller
// assumes it is bound into pmc_ctrl; one clock, synchronous active-low reset
`timescale 1ns/1ps
module pmc_ctrl_asserts #(
   parameter int N = 8
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic mode_req_valid_in,
   input wire logic [1:0] mode_req_in,
   input wire logic irq_in,
   input wire logic rtc_event_in,
   input wire logic [2:0] mode_out,
   input wire logic mode_busy_out,
   input wire logic cpu_clk_en_out,
   input wire logic mem_clk_en_out,
   input wire logic aon_pwr_out,
   input wire logic sc_pwr_out,
   input wire logic [1:0] reg_ret_out,
   input wire logic sram_ret_out,
   input wire logic periph_ret_out,
   input wire logic cpu_resume_out,
   input wire logic cpu_reset_out,
   input wire logic [1:0] reset_cause_out,
   input wire logic main_clk_src_out,
   input wire logic radio_en_out,
   input wire logic wdt_run_out,
   input wire logic wdt_pause_out,
   input wire logic [1:0] bod_mode_out,
   input wire logic [N-1:0] gpio_pad_out,
   input wire logic gpio_latched_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   AST_REQ_PREP: assert property (
      mode_out == 3'h0 && mode_req_valid_in && mode_req_in != 2'h0
      |=> mode_out == 3'h1 && mode_busy_out) else $error("mode request not taken");
   AST_PREP_LEN: assert property (
      $rose(mode_busy_out) |-> ##9 mode_busy_out ##1 !mode_busy_out)
      else $error("setup phase length wrong");
   AST_IDLE_GATE: assert property (
      mode_out == 3'h3 |-> !cpu_clk_en_out && !mem_clk_en_out)
      else $error("cpu or memory clocked in idle");
   AST_IRQ_WAKE: assert property (
      mode_out == 3'h3 && irq_in |=> mode_out == 3'h0 && cpu_resume_out)
      else $error("interrupt did not end idle");
   AST_STBY_STATE: assert property (
      mode_out == 3'h2 |-> aon_pwr_out && gpio_latched_out && reg_ret_out == 2'h1
      && periph_ret_out && wdt_pause_out && bod_mode_out == 2'h2 && !cpu_clk_en_out)
      else $error("standby outputs wrong");
   AST_STBY_WAKE: assert property (
      mode_out == 3'h2 && rtc_event_in |=> mode_out == 3'h0 && cpu_resume_out
      ##1 !cpu_resume_out) else $error("timer event did not end standby");
   AST_SHDN_OFF: assert property (
      mode_out == 3'h6 |-> !aon_pwr_out && !sc_pwr_out && reg_ret_out == 2'h0
      && !sram_ret_out && bod_mode_out == 2'h0 && !wdt_run_out && gpio_latched_out)
      else $error("shutdown outputs wrong");
   AST_PADS_FROZEN: assert property (
      gpio_latched_out && $past(gpio_latched_out) |-> $stable(gpio_pad_out))
      else $error("pads moved while latched");
   AST_HELD_CAUSE: assert property (
      mode_out == 3'h4 && $past(mode_out) == 3'h6
      |-> reset_cause_out == 2'h2 && cpu_reset_out) else $error("wake cause wrong");
   AST_RADIO: assert property (
      radio_en_out |-> main_clk_src_out) else $error("radio on without crystal");
endmodule

// *** bench/pmc_sw_model.sv ***
// software and wake-pin side of the mode controller
// assumes the bench calls its tasks; signals change at falling edges
`timescale 1ns/1ps
module pmc_sw_model #(
   parameter int N = 8
) (
   input wire logic clock_in,
   output logic mode_req_valid_out,
   output logic [1:0] mode_req_out,
   output logic [N-1:0] pin_out
);
   initial begin
      mode_req_valid_out = 1'h0;
      mode_req_out = 2'h0;
      pin_out = '0;
   end
   // one request, one cycle wide, issued only from active mode
   task automatic request(input logic [1:0] code);
      @(negedge clock_in);
      mode_req_valid_out = 1'h1;
      mode_req_out = code;
      @(negedge clock_in);
      mode_req_valid_out = 1'h0;
      mode_req_out = 2'h0;
   endtask
   task automatic set_pins(input logic [N-1:0] v);
      @(negedge clock_in);
      pin_out = v;
   endtask
endmodule

// *** bench/test_power_mode_controller.sv ***
// self-checking bench for the power mode controller
// assumes pmc_ctrl with the package pin count of eight
`timescale 1ns/1ps
module test_power_mode_controller;
   localparam int N = pmc_pkg::PIN_COUNT;
   typedef struct packed {
      logic [1:0] req;
      logic [2:0] wake;
      logic [2:0] mode;
   } pmc_row_type;
   logic clock_in, rstn_in, irq_in, rtc_event_in, sc_event_in, reset_pin_n_in;
   logic hf_src_sel_in, lf_out_req_in, radio_req_in, sc_periph_req_in, mode_req_valid_in;
   logic [1:0] mode_req_in, lf_src_sel_in, reg_ret_out, reset_cause_out;
   logic [1:0] low_clk_src_out, bod_mode_out;
   logic [N-1:0] pin_in, pin_wake_en_in, shdn_wake_en_in, gpio_core_in;
   logic [N-1:0] pin_event_out, gpio_pad_out;
   logic [2:0] mode_out;
   logic mode_busy_out, cpu_clk_en_out, mem_clk_en_out, periph_clk_en_out, aon_pwr_out;
   logic sc_pwr_out, sram_ret_out, periph_ret_out, cpu_resume_out, cpu_reset_out;
   logic main_clk_en_out, main_clk_src_out, radio_en_out, medium_clk_en_out;
   logic low_clk_en_out, lf_clk_drive_out, wdt_run_out, wdt_pause_out, bod_sample_out;
   logic por_en_out, sc_periph_owner_out, gpio_latched_out;
   int errors = 0;
   int cmp_count = 0;
   // request, wake {sensor, timer, interrupt}, mode reached
   pmc_row_type rows [5] = '{'{2'h1, 3'h1, 3'h3}, '{2'h1, 3'h2, 3'h3},
      '{2'h1, 3'h4, 3'h3}, '{2'h2, 3'h2, 3'h2}, '{2'h2, 3'h4, 3'h2}};

   pmc_ctrl #(.N(N)) uut (.clock_in, .rstn_in, .mode_req_valid_in, .mode_req_in,
      .irq_in, .rtc_event_in, .sc_event_in, .reset_pin_n_in, .pin_in, .pin_wake_en_in,
      .shdn_wake_en_in, .gpio_core_in, .hf_src_sel_in, .lf_src_sel_in, .lf_out_req_in,
      .radio_req_in, .sc_periph_req_in, .mode_out, .mode_busy_out, .cpu_clk_en_out,
      .mem_clk_en_out, .periph_clk_en_out, .aon_pwr_out, .sc_pwr_out, .reg_ret_out,
      .sram_ret_out, .periph_ret_out, .cpu_resume_out, .cpu_reset_out, .reset_cause_out,
      .main_clk_en_out, .main_clk_src_out, .radio_en_out, .medium_clk_en_out,
      .low_clk_en_out, .low_clk_src_out, .lf_clk_drive_out, .pin_event_out, .wdt_run_out,
      .wdt_pause_out, .bod_mode_out, .bod_sample_out, .por_en_out, .sc_periph_owner_out,
      .gpio_pad_out, .gpio_latched_out);
   pmc_sw_model #(.N(N)) sw (.clock_in, .mode_req_valid_out(mode_req_valid_in),
      .mode_req_out(mode_req_in), .pin_out(pin_in));

   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      int i;
      for (i = 0; i < 200 && mode_out !== m; i++) @(negedge clock_in);
      chk(8'(mode_out), 8'(m));
      if (i == 200) give_verdict();
   endtask

   initial begin
      rstn_in = 1'h0;
      irq_in = 1'h0;
      rtc_event_in = 1'h0;
      sc_event_in = 1'h0;
      reset_pin_n_in = 1'h1;
      pin_wake_en_in = 8'h00;
      shdn_wake_en_in = 8'h00;
      gpio_core_in = 8'h5a;
      hf_src_sel_in = 1'h0;
      lf_src_sel_in = 2'h0;
      lf_out_req_in = 1'h1;
      radio_req_in = 1'h0;
      sc_periph_req_in = 1'h1;
      step(3);
      chk(8'(mode_out), 8'h4);
      chk(8'(reset_cause_out), 8'h0);
      rstn_in = 1'h1;
      wait_mode(3'h0);
      chk(8'(cpu_reset_out), 8'h0);
      chk(8'(sc_periph_owner_out), 8'h1);
      chk(8'(wdt_run_out), 8'h1);
      chk(8'(bod_sample_out), 8'h1);
      foreach (rows[i]) begin
         sw.request(rows[i].req);
         wait_mode(rows[i].mode);
         chk(8'(cpu_clk_en_out), 8'h0);
         {sc_event_in, rtc_event_in, irq_in} = rows[i].wake;
         step(1);
         chk(8'(cpu_resume_out), 8'h1);
         chk(8'(mode_out), 8'h0);
         {sc_event_in, rtc_event_in, irq_in} = 3'h0;
      end
      // an interrupt during setup turns the idle entry back to active
      sw.request(2'h1);
      irq_in = 1'h1;
      step(1);
      irq_in = 1'h0;
      step(12);
      chk(8'(mode_out), 8'h0);
      chk(8'(cpu_clk_en_out), 8'h1);
      sw.request(2'h2);
      wait_mode(3'h2);
      chk(8'(reg_ret_out), 8'h1);
      chk(8'(sram_ret_out), 8'h1);
      chk(8'(periph_clk_en_out), 8'h0);
      chk(8'(main_clk_en_out), 8'h0);
      chk(8'(low_clk_en_out), 8'h1);
      chk(8'(por_en_out), 8'h1);
      gpio_core_in = 8'ha5;
      irq_in = 1'h1;
      step(3);
      chk(8'(mode_out), 8'h2);
      chk(gpio_pad_out, 8'h5a);
      chk(8'(bod_sample_out), 8'h0);
      irq_in = 1'h0;
      pin_wake_en_in = 8'h01;
      sw.set_pins(8'h01);
      wait_mode(3'h0);
      chk(pin_event_out, 8'h01);
      step(2);
      chk(gpio_pad_out, 8'ha5);
      pin_wake_en_in = 8'h00;
      shdn_wake_en_in = 8'h02;
      sw.request(2'h3);
      wait_mode(3'h6);
      chk(8'(por_en_out), 8'h0);
      chk(8'(low_clk_en_out), 8'h0);
      chk(8'(sc_periph_owner_out), 8'h0);
      chk(8'(bod_sample_out), 8'h0);
      rtc_event_in = 1'h1;
      step(1);
      rtc_event_in = 1'h0;
      step(1);
      chk(8'(mode_out), 8'h6);
      sw.set_pins(8'h03);
      wait_mode(3'h4);
      chk(8'(reset_cause_out), 8'h2);
      wait_mode(3'h0);
      sw.request(2'h0);
      step(2);
      chk(8'(mode_out), 8'h0);
      reset_pin_n_in = 1'h0;
      wait_mode(3'h4);
      chk(8'(reset_cause_out), 8'h1);
      reset_pin_n_in = 1'h1;
      wait_mode(3'h0);
      radio_req_in = 1'h1;
      step(2);
      chk(8'(radio_en_out), 8'h0);
      hf_src_sel_in = 1'h1;
      lf_src_sel_in = 2'h2;
      step(2);
      chk(8'(radio_en_out), 8'h1);
      chk(8'(main_clk_src_out), 8'h1);
      chk(8'(low_clk_src_out), 8'h2);
      chk(8'(lf_clk_drive_out), 8'h0);
      lf_src_sel_in = 2'h1;
      step(2);
      chk(8'(lf_clk_drive_out), 8'h1);
      chk(8'(medium_clk_en_out), 8'h1);
      give_verdict();
   end
endmodule

bind pmc_ctrl pmc_ctrl_asserts #(.N(N)) chk_i (.clock_in, .rstn_in, .mode_req_valid_in,
   .mode_req_in, .irq_in, .rtc_event_in, .mode_out, .mode_busy_out, .cpu_clk_en_out,
   .mem_clk_en_out, .aon_pwr_out, .sc_pwr_out, .reg_ret_out, .sram_ret_out, .periph_ret_out,
   .cpu_resume_out, .cpu_reset_out, .reset_cause_out, .main_clk_src_out, .radio_en_out,
   .wdt_run_out, .wdt_pause_out, .bod_mode_out, .gpio_pad_out, .gpio_latched_out);
